// ==== include/adc_seq_defines.svh ====
// offsets, field positions, reset values and counts of the sequencer
`ifndef ADC_SEQ_DEFINES_SVH
`define ADC_SEQ_DEFINES_SVH

`define ADDR_CTRL0 4'h0
`define ADDR_CTRL1 4'h1
`define ADDR_RESULT_HI 4'h2
`define ADDR_RESULT_LO 4'h3
`define ADDR_ACFG_LO 4'h4
`define ADDR_ACFG_HI 4'h5
`define ADDR_DIR_LO 4'h6
`define ADDR_DIR_HI 4'h7
`define ADDR_PORT_LO 4'h8
`define ADDR_PORT_HI 4'h9
`define ADDR_CMP_CTRL 4'hA
`define ADDR_STATUS 4'hB

`define CTRL0_ENABLE_BIT 0
`define CTRL0_START_BIT 1
`define CTRL0_CHAN_LSB 2
`define CTRL1_CLKSEL_LSB 0
`define CTRL1_ACQ_LSB 3
`define CTRL1_CAL_BIT 6
`define STATUS_DONE_BIT 0
`define STATUS_CAL_BIT 1

`define ACFG_RESET 16'h0000
`define DIR_RESET 16'hFFFF
`define CMP_MODE_RESET 4'h0

`define CONV_PERIODS 5'h0B
`define WAIT_PERIODS 5'h02
`define HOLD_PHASE 5'h0A
`define INSTR_OSC 5'h04
`define TRIG_MODE 4'hB
`define SAR_FIRST 10'h200

`endif

// ==== include/adc_seq_pkg.sv ====
// types shared by the conversion sequencer
package adc_seq_pkg;

  typedef enum logic [2:0] {
    S_IDLE, S_DELAY, S_ACQ, S_CONV, S_WAIT
  } seq_state_t;

  typedef struct packed {
    logic [3:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } reg_bus_t;

  typedef struct packed {
    seq_state_t state;
    logic converter_enable;
    logic start_done;
    logic [3:0] channel_select;
    logic [2:0] conv_clock_select;
    logic [2:0] acquisition_time_select;
    logic calibration_enable;
    logic [1:0] result_high_byte;
    logic [7:0] result_low_byte;
    logic [15:0] analog_config;
    logic [15:0] pin_direction_bit;
    logic [3:0] compare_mode_field;
    logic conversion_done_flag;
    logic calibrated;
    logic [9:0] offset;
    logic dummy;
    logic [9:0] sar;
    logic [4:0] cnt;
    logic sample;
    logic timer_clear;
    logic [7:0] rdata;
  } seq_regs_t;

endpackage : adc_seq_pkg

// ==== core/bit_period_divider.sv ====
// per-bit conversion period divider: one-cycle tick per period
`include "adc_seq_defines.svh"
module bit_period_divider #(
  parameter int CNT_W = 6
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic [2:0] clk_sel,
  input wire logic rc_tick,
  input wire logic restart,
  output logic tick
);

  if (CNT_W < 6) begin : g_cnt_w_check
    $error("divider counter too narrow for 64 periods");
  end

  typedef struct packed {
    logic [CNT_W-1:0] cnt;
    logic tick;
  } div_regs_t;

  div_regs_t r;
  div_regs_t n;

  // 000:2 100:4 001:8 101:16 010:32 110:64 oscillator periods
  function automatic logic [CNT_W-1:0] last_count(input logic [2:0] s);
    logic [6:0] per;
    per = 7'h02 << {s[1:0], s[2]};
    return CNT_W'(per - 7'h01);
  endfunction : last_count

  always_comb begin
    n = r;
    n.tick = 1'b0;
    if (restart) begin
      n.cnt = '0;
    end else if (clk_sel[1:0] == 2'b11) begin
      n.tick = rc_tick;
      n.cnt = '0;
    end else if (r.cnt >= last_count(clk_sel)) begin
      n.cnt = '0;
      n.tick = 1'b1;
    end else begin
      n.cnt = r.cnt + 1'b1;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end

  assign tick = r.tick;

  AST_DIV_TWO: assert property (@(posedge clock) disable iff (!rst_n)
    (r.tick && clk_sel == 3'b000 && !restart)
    ##1 (clk_sel == 3'b000 && !restart) |=> r.tick)
    else $error("two-period select does not tick every second cycle");

  AST_DIV_RC: assert property (@(posedge clock) disable iff (!rst_n)
    (clk_sel[1:0] == 2'b11 && !restart) |=> (r.tick == $past(rc_tick)))
    else $error("rc selection does not follow the rc source");

endmodule : bit_period_divider

// ==== core/adc_conversion_sequencer.sv ====
// control and sequencing logic of a 10-bit successive-approximation converter
//
// Decided for this implementation: the register offsets and strobed register access.
`include "adc_seq_defines.svh"
module adc_conversion_sequencer (
  input wire logic clock,
  input wire logic resetn,
  input wire adc_seq_pkg::reg_bus_t bus,
  input wire logic rc_tick,
  input wire logic cmp_in,
  input wire logic [15:0] pin_level,
  input wire logic trig_event,
  output logic [7:0] rdata,
  output logic sample_connect,
  output logic [3:0] channel_sel,
  output logic dummy_conv,
  output logic [9:0] sar_code,
  output logic timer_clear,
  output logic done_flag,
  output logic [15:0] pin_dir,
  output logic [15:0] pin_analog
);

  logic [1:0] rst_sync_r;
  logic rst_n;
  adc_seq_pkg::seq_regs_t r;
  adc_seq_pkg::seq_regs_t n;
  logic tick;
  logic restart;
  logic complete;

  // two-stage release so the async reset leaves all flops together
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      rst_sync_r <= 2'b00;
    end else begin
      rst_sync_r <= {rst_sync_r[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_r[1];

  bit_period_divider #(.CNT_W(6)) u_div (
    .clock(clock),
    .rst_n(rst_n),
    .clk_sel(r.conv_clock_select),
    .rc_tick(rc_tick),
    .restart(restart),
    .tick(tick)
  );

  function automatic logic [4:0] acq_periods(input logic [2:0] s);
    case (s)
      3'b000: return 5'h00;
      3'b001: return 5'h02;
      3'b010: return 5'h04;
      3'b011: return 5'h06;
      3'b100: return 5'h08;
      3'b101: return 5'h0C;
      3'b110: return 5'h10;
      default: return 5'h14;
    endcase
  endfunction : acq_periods

  // offset from calibration is removed, clamped at zero
  function automatic logic [9:0] trim(input logic [9:0] raw,
                                      input logic [9:0] off);
    return (raw > off) ? raw - off : 10'h000;
  endfunction : trim

  always_comb begin
    logic [9:0] sar_v;
    logic [15:0] port_v;
    logic done_set;
    n = r;
    sar_v = r.sar;
    port_v = pin_level & r.analog_config;
    done_set = 1'b0;
    restart = 1'b0;
    complete = 1'b0;
    n.timer_clear = 1'b0;
    n.rdata = 8'h00;
    case (r.state)
      adc_seq_pkg::S_IDLE: begin
        if (r.converter_enable && r.start_done) begin
          n.dummy = r.calibration_enable;
          if (r.acquisition_time_select == 3'b000) begin
            n.state = adc_seq_pkg::S_DELAY;
            n.cnt = `INSTR_OSC - 5'h01;
          end else begin
            n.state = adc_seq_pkg::S_ACQ;
            n.cnt = acq_periods(r.acquisition_time_select) - 5'h01;
            restart = 1'b1;
          end
        end
      end
      adc_seq_pkg::S_DELAY: begin
        if (!r.start_done) begin
          n.state = adc_seq_pkg::S_WAIT;
          n.cnt = `WAIT_PERIODS - 5'h01;
          restart = 1'b1;
        end else if (r.cnt == 5'h00) begin
          n.state = adc_seq_pkg::S_CONV;
          n.cnt = `CONV_PERIODS - 5'h01;
          sar_v = `SAR_FIRST;
          restart = 1'b1;
        end else begin
          n.cnt = r.cnt - 5'h01;
        end
      end
      adc_seq_pkg::S_ACQ: begin
        if (!r.start_done) begin
          n.state = adc_seq_pkg::S_WAIT;
          n.cnt = `WAIT_PERIODS - 5'h01;
          restart = 1'b1;
        end else if (tick) begin
          if (r.cnt == 5'h00) begin
            n.state = adc_seq_pkg::S_CONV;
            n.cnt = `CONV_PERIODS - 5'h01;
            sar_v = `SAR_FIRST;
            restart = 1'b1;
          end else begin
            n.cnt = r.cnt - 5'h01;
          end
        end
      end
      adc_seq_pkg::S_CONV: begin
        if (!r.start_done) begin
          // partial code is dropped, result pair untouched
          n.state = adc_seq_pkg::S_WAIT;
          n.cnt = `WAIT_PERIODS - 5'h01;
          restart = 1'b1;
        end else if (tick) begin
          // first period holds the sample, then one bit per period
          if (r.cnt != `HOLD_PHASE) begin
            if (!cmp_in) begin
              sar_v[r.cnt[3:0]] = 1'b0;
            end
            if (r.cnt != 5'h00) begin
              sar_v[r.cnt[3:0] - 4'h1] = 1'b1;
            end
          end
          if (r.cnt == 5'h00) begin
            complete = 1'b1;
            if (r.dummy) begin
              n.offset = sar_v;
              n.calibrated = 1'b1;
            end else begin
              {n.result_high_byte, n.result_low_byte} =
                trim(sar_v, r.offset);
            end
            n.start_done = 1'b0;
            done_set = 1'b1;
            n.state = adc_seq_pkg::S_WAIT;
            n.cnt = `WAIT_PERIODS - 5'h01;
            restart = 1'b1;
          end else begin
            n.cnt = r.cnt - 5'h01;
          end
        end
      end
      adc_seq_pkg::S_WAIT: begin
        if (tick) begin
          if (r.cnt == 5'h00) begin
            n.state = adc_seq_pkg::S_IDLE;
            n.dummy = 1'b0;
          end else begin
            n.cnt = r.cnt - 5'h01;
          end
        end
      end
      default: begin
        n.state = adc_seq_pkg::S_IDLE;
      end
    endcase
    n.sar = sar_v;

    // software writes land after the machine; the done set comes later
    if (bus.wr) begin
      case (bus.addr)
        `ADDR_CTRL0: begin
          n.converter_enable = bus.wdata[`CTRL0_ENABLE_BIT];
          n.start_done = bus.wdata[`CTRL0_START_BIT];
          n.channel_select = bus.wdata[`CTRL0_CHAN_LSB +: 4];
        end
        `ADDR_CTRL1: begin
          n.conv_clock_select = bus.wdata[`CTRL1_CLKSEL_LSB +: 3];
          n.acquisition_time_select = bus.wdata[`CTRL1_ACQ_LSB +: 3];
          n.calibration_enable = bus.wdata[`CTRL1_CAL_BIT];
        end
        `ADDR_RESULT_HI: n.result_high_byte = bus.wdata[1:0];
        `ADDR_RESULT_LO: n.result_low_byte = bus.wdata;
        `ADDR_ACFG_LO: n.analog_config[7:0] = bus.wdata;
        `ADDR_ACFG_HI: n.analog_config[15:8] = bus.wdata;
        `ADDR_DIR_LO: n.pin_direction_bit[7:0] = bus.wdata;
        `ADDR_DIR_HI: n.pin_direction_bit[15:8] = bus.wdata;
        `ADDR_CMP_CTRL: n.compare_mode_field = bus.wdata[3:0];
        `ADDR_STATUS: begin
          n.conversion_done_flag = bus.wdata[`STATUS_DONE_BIT] &
                                   r.conversion_done_flag;
        end
        default: begin
        end
      endcase
    end

    if (trig_event && r.compare_mode_field == `TRIG_MODE) begin
      n.timer_clear = 1'b1;
      if (n.converter_enable) begin
        n.start_done = 1'b1;
      end
    end

    if (done_set) begin
      n.conversion_done_flag = 1'b1;
    end

    if (!n.converter_enable) begin
      n.state = adc_seq_pkg::S_IDLE;
      n.start_done = 1'b0;
      n.dummy = 1'b0;
    end

    // sampling runs while enabled in idle, delay and acquisition, never in wait or in a dummy conversion
    n.sample = n.converter_enable && !n.dummy &&
               (n.state == adc_seq_pkg::S_IDLE ||
                n.state == adc_seq_pkg::S_DELAY ||
                n.state == adc_seq_pkg::S_ACQ);

    if (bus.rd) begin
      case (bus.addr)
        `ADDR_CTRL0: n.rdata = {2'b00, r.channel_select, r.start_done,
                                r.converter_enable};
        `ADDR_CTRL1: n.rdata = {1'b0, r.calibration_enable,
                                r.acquisition_time_select,
                                r.conv_clock_select};
        `ADDR_RESULT_HI: n.rdata = {6'h00, r.result_high_byte};
        `ADDR_RESULT_LO: n.rdata = r.result_low_byte;
        `ADDR_ACFG_LO: n.rdata = r.analog_config[7:0];
        `ADDR_ACFG_HI: n.rdata = r.analog_config[15:8];
        `ADDR_DIR_LO: n.rdata = r.pin_direction_bit[7:0];
        `ADDR_DIR_HI: n.rdata = r.pin_direction_bit[15:8];
        `ADDR_PORT_LO: n.rdata = port_v[7:0];
        `ADDR_PORT_HI: n.rdata = port_v[15:8];
        `ADDR_CMP_CTRL: n.rdata = {4'h0, r.compare_mode_field};
        `ADDR_STATUS: n.rdata = {6'h00, r.calibrated,
                                 r.conversion_done_flag};
        default: n.rdata = 8'h00;
      endcase
    end
  end

  // result pair has no reset: a device reset must leave it as it was
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      r.state <= adc_seq_pkg::S_IDLE;
      r.converter_enable <= 1'b0;
      r.start_done <= 1'b0;
      r.channel_select <= 4'h0;
      r.conv_clock_select <= 3'h0;
      r.acquisition_time_select <= 3'h0;
      r.calibration_enable <= 1'b0;
      r.analog_config <= `ACFG_RESET;
      r.pin_direction_bit <= `DIR_RESET;
      r.compare_mode_field <= `CMP_MODE_RESET;
      r.conversion_done_flag <= 1'b0;
      r.calibrated <= 1'b0;
      r.offset <= 10'h000;
      r.dummy <= 1'b0;
      r.sar <= 10'h000;
      r.cnt <= 5'h00;
      r.sample <= 1'b0;
      r.timer_clear <= 1'b0;
      r.rdata <= 8'h00;
    end else begin
      r <= n;
    end
  end

  // channel mux and direction pass straight to the pads: a pin driven as
  // output is converted at its driven level, a digital input still
  // presents its analog level to the mux
  assign rdata = r.rdata;
  assign sample_connect = r.sample;
  assign channel_sel = r.channel_select;
  assign dummy_conv = r.dummy;
  assign sar_code = r.sar;
  assign timer_clear = r.timer_clear;
  assign done_flag = r.conversion_done_flag;
  assign pin_dir = r.pin_direction_bit;
  assign pin_analog = ~r.analog_config;

  // ticks seen since entering the current state
  logic [4:0] ph_ticks;
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      ph_ticks <= 5'h00;
    end else if (n.state != r.state) begin
      ph_ticks <= 5'h00;
    end else if (tick) begin
      ph_ticks <= ph_ticks + 5'h01;
    end
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);

  sequence seq_quick_start;
    r.state == adc_seq_pkg::S_IDLE && r.converter_enable && r.start_done &&
    r.acquisition_time_select == 3'b000;
  endsequence

  sequence seq_delay_run;
    (r.state == adc_seq_pkg::S_DELAY && r.start_done)[*4];
  endsequence

  AST_CONV_ELEVEN: assert property (complete |-> ph_ticks == 5'h0A)
    else $error("conversion did not span eleven bit periods");

  AST_PORT_MASK: assert property (
    bus.rd && bus.addr == `ADDR_PORT_LO |=>
    rdata == ($past(pin_level[7:0]) & $past(r.analog_config[7:0])))
    else $error("analog pin read back as nonzero");

  AST_NO_ACQ_DELAY: assert property (
    seq_quick_start ##1 seq_delay_run |=> r.state == adc_seq_pkg::S_CONV)
    else $error("no-acquisition start not one instruction late");

  AST_ACQ_FOUR: assert property (
    r.state == adc_seq_pkg::S_ACQ && n.state == adc_seq_pkg::S_CONV &&
    r.acquisition_time_select == 3'b010 |-> ph_ticks == 5'h03)
    else $error("acquisition of 010 not four bit periods");

  AST_ABORT_KEEP: assert property (
    r.state == adc_seq_pkg::S_CONV && !r.start_done && !bus.wr |=>
    $stable({r.result_high_byte, r.result_low_byte}) &&
    r.state == adc_seq_pkg::S_WAIT)
    else $error("abort disturbed the result pair");

  AST_WAIT_TWO: assert property (
    r.state == adc_seq_pkg::S_WAIT && tick && n.converter_enable |->
    (ph_ticks == 5'h01) == (n.state == adc_seq_pkg::S_IDLE))
    else $error("post-conversion wait not two bit periods");

  AST_TRIG_START: assert property (
    trig_event && r.compare_mode_field == `TRIG_MODE &&
    r.converter_enable && !bus.wr |=> r.start_done)
    else $error("special trigger did not set start");

  AST_TRIG_TIMER: assert property (
    trig_event && r.compare_mode_field == `TRIG_MODE |=> timer_clear)
    else $error("special trigger did not clear the timer");

  AST_DUMMY_OPEN: assert property (
    r.dummy |-> !sample_connect)
    else $error("dummy conversion sampled an input");

  AST_DONE_SET: assert property (
    complete && n.converter_enable |=> done_flag && !r.sample &&
    r.state == adc_seq_pkg::S_WAIT ##3 r.state != adc_seq_pkg::S_CONV)
    else $error("completion did not raise the done flag");

  AST_DISABLED_IDLE: assert property (
    !r.converter_enable |-> r.state == adc_seq_pkg::S_IDLE && !r.start_done)
    else $error("disabled converter left idle");

endmodule : adc_conversion_sequencer

// ==== test/analog_pin_model.sv ====
// behavioural model of the analog pins and hold capacitor ahead of the sar
module analog_pin_model #(
  parameter logic [9:0] OFFSET = 10'h005
) (
  input wire logic clock,
  input wire logic sample_connect,
  input wire logic dummy_conv,
  input wire logic [3:0] channel_sel,
  input wire logic [9:0] sar_code,
  input wire logic [15:0] pin_dir,
  input wire logic [15:0] pin_level,
  input wire logic [9:0] vin [16],
  output logic cmp_in
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [10:0] src;
  logic [9:0] held_r = 10'h000;
  always_comb begin
    // an output pin presents its driven rail, an input its analog level
    src = {1'b0, pin_dir[channel_sel] ? vin[channel_sel]
        : {10{pin_level[channel_sel]}}} + {1'b0, OFFSET};
    if (src > 11'h3FF) src = 11'h3FF;
  end
  // the cap keeps its charge once the switch opens
  always_ff @(posedge clock) begin
    if (sample_connect) held_r <= src[9:0];
  end
  // a dummy conversion sees only the built-in offset, no channel
  assign cmp_in = (dummy_conv ? OFFSET : held_r) >= sar_code;
endmodule : analog_pin_model

// ==== test/adc_conversion_sequencer_tb_top.sv ====
// self-checking bench of the conversion sequencer
`include "adc_seq_defines.svh"
module adc_conversion_sequencer_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [9:0] OFS = 10'h005;
  logic clock = 1'b0;
  logic resetn = 1'b0;
  adc_seq_pkg::reg_bus_t bus = '0;
  logic rc_tick = 1'b0;
  logic cmp_in;
  logic [15:0] pin_level = 16'h0000;
  logic trig_event = 1'b0;
  logic [7:0] rdata;
  logic sample_connect, dummy_conv, timer_clear, done_flag;
  logic [3:0] channel_sel;
  logic [9:0] sar_code;
  logic [15:0] pin_dir, pin_analog;
  logic [9:0] vin [16];
  logic [15:0] dir_r = 16'hFFFF;
  logic cal_done = 1'b0;
  int dummy_cycles = 0;
  int n_errors = 0;
  int n_compared = 0;
  int rc_cnt = 0;

  always #4 clock = ~clock;

  // rc source runs free at ten clocks per period and never stops while a
  // conversion runs, as it would with the device held asleep
  always @(posedge clock) begin
    rc_cnt <= (rc_cnt == 9) ? 0 : rc_cnt + 1;
    rc_tick <= (rc_cnt == 9);
    if (dummy_conv === 1'b1) dummy_cycles <= dummy_cycles + 1;
  end

  adc_conversion_sequencer dut (.clock(clock), .resetn(resetn), .bus(bus),
    .rc_tick(rc_tick), .cmp_in(cmp_in), .pin_level(pin_level),
    .trig_event(trig_event), .rdata(rdata), .sample_connect(sample_connect),
    .channel_sel(channel_sel), .dummy_conv(dummy_conv), .sar_code(sar_code),
    .timer_clear(timer_clear), .done_flag(done_flag), .pin_dir(pin_dir),
    .pin_analog(pin_analog));

  analog_pin_model #(.OFFSET(OFS)) pins (.clock(clock),
    .sample_connect(sample_connect), .dummy_conv(dummy_conv),
    .channel_sel(channel_sel), .sar_code(sar_code), .pin_dir(pin_dir),
    .pin_level(pin_level), .vin(vin), .cmp_in(cmp_in));

  function automatic int per(input logic [2:0] cs);
    case (cs)
      3'b000: return 2;
      3'b100: return 4;
      3'b001: return 8;
      3'b101: return 16;
      3'b010: return 32;
      3'b110: return 64;
      default: return 10;
    endcase
  endfunction : per

  function automatic int acq_n(input logic [2:0] a);
    int t [8] = '{0, 2, 4, 6, 8, 12, 16, 20};
    return t[a];
  endfunction : acq_n

  function automatic logic [9:0] expect_res(input logic [3:0] ch);
    logic [10:0] raw;
    raw = {1'b0, dir_r[ch] ? vin[ch] : {10{pin_level[ch]}}} + {1'b0, OFS};
    if (raw > 11'h3FF) raw = 11'h3FF;
    if (cal_done) raw = (raw > {1'b0, OFS}) ? raw - {1'b0, OFS} : 11'h000;
    return raw[9:0];
  endfunction : expect_res

  task automatic chk(input string nm, input logic [15:0] e,
      input logic [15:0] g);
    n_compared++;
    if (g !== e) begin
      n_errors++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task automatic chk_rng(input string nm, input int lo, input int hi,
      input int g);
    n_compared++;
    if (g < lo || g > hi) begin
      n_errors++;
      $display("mismatch %s expected %0d..%0d seen %0d", nm, lo, hi, g);
    end
  endtask : chk_rng

  task automatic reg_wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clock);
    bus <= '{a, d, 1'b1, 1'b0};
    @(posedge clock);
    bus <= '0;
  endtask : reg_wr

  task automatic reg_rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge clock);
    bus <= '{a, 8'h00, 1'b0, 1'b1};
    @(posedge clock);
    bus <= '0;
    #1;
    d = rdata;
  endtask : reg_rd

  task automatic rd_chk(input string nm, input logic [3:0] a,
      input logic [7:0] e);
    logic [7:0] d;
    reg_rd(a, d);
    chk(nm, {8'h00, e}, {8'h00, d});
  endtask : rd_chk

  // bounded wait; a hang shows up as an out-of-range count
  task automatic wait_hi(input bit smp, output int t);
    t = 0;
    while ((smp ? sample_connect : done_flag) !== 1'b1 && t < 3000) begin
      @(posedge clock);
      #1;
      t++;
    end
  endtask : wait_hi

  task automatic pulse_trig();
    @(posedge clock);
    trig_event <= 1'b1;
    @(posedge clock);
    trig_event <= 1'b0;
    #1;
    chk("timer_clear", 16'h0001, {15'h0, timer_clear});
  endtask : pulse_trig

  task automatic convert(input logic [3:0] ch, input logic [2:0] cs,
      input logic [2:0] acq, input logic cal, input logic trig);
    int p;
    int t;
    logic [7:0] hi;
    logic [7:0] lo;
    logic [9:0] old;
    int d0;
    p = per(cs);
    reg_rd(`ADDR_RESULT_HI, hi);
    reg_rd(`ADDR_RESULT_LO, lo);
    old = {hi[1:0], lo};
    d0 = dummy_cycles;
    // clock and acquisition settings stay fixed until the conversion ends
    reg_wr(`ADDR_CTRL1, {1'b0, cal, acq, cs});
    reg_wr(`ADDR_CTRL0, {2'b00, ch, !trig, 1'b1});
    if (trig) pulse_trig();
    wait_hi(1'b0, t);
    p = p * (11 + acq_n(acq));
    chk_rng("conv_time", p - per(cs) + 2, p + 8, t);
    wait_hi(1'b1, t);
    chk_rng("wait_time", per(cs), 2 * per(cs) + 3, t);
    chk("dummy", {15'h0, cal}, {15'h0, dummy_cycles != d0});
    rd_chk("status", `ADDR_STATUS, {6'h00, cal | cal_done, 1'b1});
    rd_chk("start_clr", `ADDR_CTRL0, {2'b00, ch, 2'b01});
    reg_rd(`ADDR_RESULT_HI, hi);
    reg_rd(`ADDR_RESULT_LO, lo);
    old = cal ? old : expect_res(ch);
    chk("result", {6'h00, old}, {6'h00, hi[1:0], lo});
    rd_chk("ctrl1", `ADDR_CTRL1, {1'b0, cal, acq, cs});
    reg_wr(`ADDR_STATUS, 8'h00);
  endtask : convert

  task automatic end_test(input string nm);
    $display("test %s done", nm);
  endtask : end_test

  task automatic print_verdict();
    $display("compared %0d mismatches %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : print_verdict

  initial begin
    repeat (20000) @(posedge clock);
    n_errors++;
    $display("mismatch watchdog expected finish seen hang");
    print_verdict();
  end

  initial begin
    logic [15:0] acfg;
    int t;
    void'($urandom(64562));
    foreach (vin[i]) vin[i] = 10'($urandom_range(10'h3F0, 0));
    repeat (3) @(posedge clock);
    resetn <= 1'b1;
    repeat (3) @(posedge clock);
    rd_chk("ctrl0", `ADDR_CTRL0, 8'h00);
    rd_chk("acfg_lo", `ADDR_ACFG_LO, 8'h00);
    rd_chk("dir_hi", `ADDR_DIR_HI, 8'hFF);
    for (int a = 12; a < 16; a++) rd_chk("unmapped", 4'(a), 8'h00);
    end_test("reset");
    reg_wr(`ADDR_CTRL0, 8'h02);
    rd_chk("start_off", `ADDR_CTRL0, 8'h00);
    reg_wr(`ADDR_CMP_CTRL, 8'h0B);
    rd_chk("cmp_mode", `ADDR_CMP_CTRL, 8'h0B);
    pulse_trig();
    repeat (30) @(posedge clock);
    rd_chk("trig_off", `ADDR_CTRL0, 8'h00);
    chk("done_idle", 16'h0000, {15'h0, done_flag});
    end_test("disabled");
    // enable alone first; the start comes in a later write, or from the special trigger in the trigger test
    reg_wr(`ADDR_CTRL0, 8'h01);
    for (int c = 0; c < 8; c++)
      convert(4'($urandom_range(15, 0)), 3'(c), 3'b000, 0, 0);
    end_test("clock_select");
    for (int a = 0; a < 8; a++)
      convert(4'($urandom_range(15, 0)), 3'b100, 3'(a), 0, 0);
    convert(4'($urandom_range(15, 0)), 3'b001, 3'b010, 0, 0);
    end_test("acquisition");
    acfg = 16'($urandom);
    dir_r = 16'($urandom);
    pin_level <= 16'($urandom);
    reg_wr(`ADDR_ACFG_LO, acfg[7:0]);
    reg_wr(`ADDR_ACFG_HI, acfg[15:8]);
    reg_wr(`ADDR_DIR_LO, dir_r[7:0]);
    reg_wr(`ADDR_DIR_HI, dir_r[15:8]);
    rd_chk("port_lo", `ADDR_PORT_LO, pin_level[7:0] & acfg[7:0]);
    rd_chk("port_hi", `ADDR_PORT_HI, pin_level[15:8] & acfg[15:8]);
    chk("analog", ~acfg, pin_analog);
    chk("dir", dir_r, pin_dir);
    for (int k = 0; k < 6; k++)
      convert(4'($urandom_range(15, 0)), 3'b000, 3'b000, 0, 0);
    end_test("pins");
    convert(4'($urandom_range(15, 0)), 3'b000, 3'b000, 1, 0);
    cal_done = 1'b1;
    convert(4'($urandom_range(15, 0)), 3'b100, 3'b000, 0, 0);
    end_test("calibration");
    convert(4'($urandom_range(15, 0)), 3'b000, 3'b001, 0, 1);
    end_test("trigger");
    reg_wr(`ADDR_RESULT_HI, 8'h01);
    reg_wr(`ADDR_RESULT_LO, 8'h55);
    reg_wr(`ADDR_CTRL1, 8'h06);
    reg_wr(`ADDR_CTRL0, 8'h03);
    repeat (300) @(posedge clock);
    reg_wr(`ADDR_CTRL0, 8'h01);
    wait_hi(1'b1, t);
    chk_rng("abort_wait", 64, 131, t);
    chk("abort_done", 16'h0000, {15'h0, done_flag});
    rd_chk("keep_hi", `ADDR_RESULT_HI, 8'h01);
    rd_chk("keep_lo", `ADDR_RESULT_LO, 8'h55);
    end_test("abort");
    reg_wr(`ADDR_CTRL0, 8'h03);
    repeat (200) @(posedge clock);
    resetn <= 1'b0;
    repeat (2) @(posedge clock);
    resetn <= 1'b1;
    repeat (3) @(posedge clock);
    rd_chk("rst_ctrl0", `ADDR_CTRL0, 8'h00);
    rd_chk("rst_lo", `ADDR_RESULT_LO, 8'h55);
    chk("rst_done", 16'h0000, {15'h0, done_flag});
    end_test("reset_abort");
    print_verdict();
  end
endmodule : adc_conversion_sequencer_tb_top
